// ===== verilog/board_regs_pkg.sv
package board_regs_pkg;
  // I2C slave addresses (7 bit)
  localparam logic [6:0] MGMT_ADDR = 7'h31;
  localparam logic [6:0] HOST_ADDR = 7'h32;
  // Register offsets
  localparam logic [7:0] OFF_RST_LOCAL = 8'h0E;
  localparam logic [7:0] OFF_RST_REMOTE = 8'h0F;
  localparam logic [7:0] OFF_SUPPLY = 8'h10;
  localparam logic [7:0] OFF_STANDBY = 8'h11;
  localparam logic [7:0] OFF_REGULATOR = 8'h12;
  localparam logic [7:0] OFF_EXP_IRQ = 8'h13;
  localparam logic [7:0] OFF_SUMMARY = 8'h14;
  localparam logic [7:0] OFF_CPU_MOD = 8'h18;
  localparam logic [7:0] OFF_LAMP = 8'h1B;
  localparam logic [7:0] OFF_DEBUG = 8'h1C;
  localparam logic [7:0] OFF_BRIDGE = 8'h1F;
  localparam logic [7:0] OFF_M_SUPPLY = 8'h20;
  localparam logic [7:0] OFF_M_STANDBY = 8'h21;
  localparam logic [7:0] OFF_M_REG = 8'h22;
  localparam logic [7:0] OFF_M_EXP = 8'h23;
  localparam logic [7:0] OFF_M_ALERT = 8'h24;
  localparam logic [7:0] OFF_M_GLOBAL = 8'h25;
  // Implemented flag bits of the reset-source registers
  localparam logic [7:0] RST_LOCAL_BITS = 8'hF7;
  localparam logic [6:0] RST_REMOTE_BITS = 7'h7F;
  // Reset value of all mask registers
  localparam logic [7:0] MASK_RST = 8'h00;
  // Level of each status bit in its non-interrupting state
  localparam logic [7:0] SUPPLY_NORMAL = 8'hEE;
  localparam logic [7:0] STANDBY_NORMAL = 8'h01;
  localparam logic [7:0] REG_NORMAL = 8'h15;
  localparam logic [7:0] EXP_NORMAL = 8'h3F;
  localparam logic [7:0] ALERT_NORMAL = 8'h1F;
  // Reserved bit fill values on read
  localparam logic [1:0] EXP_RSVD = 2'h3;
  localparam logic [1:0] LAMP_RSVD_HI = 2'h3;
  localparam logic [3:0] BRIDGE_RSVD = 4'hF;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // All asynchronous inputs, sampled together
  typedef struct packed {
    logic scl;
    logic sda;
    logic [7:0] ev_loc;
    logic [6:0] ev_rem;
    logic [7:0] supply;
    logic stby;
    logic [5:0] rails;
    logic [5:0] exp_n;
    logic tpm_n;
    logic [7:0] cpu;
    logic [1:0] lamp_n;
    logic [6:0] dbg;
    logic [4:0] alert;
    logic [3:0] bridge;
    logic optical_n;
  } pins_t;
  localparam int PINS_W = $bits(pins_t);
  // Quiet levels of all pins, so no false interrupt follows reset
  localparam pins_t PINS_IDLE = '{scl: 1'b1, sda: 1'b1, supply: SUPPLY_NORMAL,
    stby: STANDBY_NORMAL[0], rails: REG_NORMAL[5:0], exp_n: EXP_NORMAL[5:0], tpm_n: 1'b1,
    alert: ALERT_NORMAL[4:0], optical_n: 1'b1, default: '0};
  localparam logic [PINS_W-1:0] PINS_RST = PINS_IDLE;
endpackage

// ===== verilog/pin_sync_if.sv
`timescale 1ns/1ns
interface pin_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport src (output raw, input synced);
  modport sync (input raw, output synced);
endinterface

// ===== verilog/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input logic clk,
  input logic rst,
  pin_sync_if.sync p
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t s_r;
  sync_state_t s_nxt;

  // Two flop chain, only the second stage leaves
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = p.raw;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= {RST_VAL, RST_VAL};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign p.synced = s_r.s2;
endmodule // pin_sync

// ===== verilog/board_status_regs.sv
`timescale 1ns/1ns
// Summary of operation
// - 0x0E bits 0-2 flag front, board and header button resets; bit 3 reserved.
// - 0x0E bits 4-7 flag software hot, warm, cold and power resets.
// - 0x0F bits 0-4 flag controller-requested resets: self, switch, module, main, board.
// - 0x0F bits 5-6 flag controller watchdog 1 and 2 resets; bit 7 reserved.
// - Reset-source flags read 1 after their reset, 0 otherwise, default 0.
// - 0x10 bits 0 and 4 give supply unit presence, low means present.
// - 0x10 bits 1,2 and 5,6 read 1 when output and input are good.
// - 0x10 bits 3 and 7 give supply alarms, low means alarm.
// - 0x11 bit 0 shows standby power good; bits 1-7 read 0.
// - 0x12 bits 0,2,4 show core, analog, 3.3 V regulator ready.
// - 0x12 bits 1,3,5 show core, analog, 3.3 V over-temperature.
// - 0x13 bits 0-5 mirror six active-low expander interrupts.
// - 0x14 bits 0-4 show active-low summary interrupts; bits 5-7 reserved.
// - 0x18 shows module board type, gigabit link and sleep state levels.
// - 0x1B bits 0-1 show active-low upper and lower lamp row selection.
// - 0x1C shows live levels of buttons, serial selects and PCIe reset.
// - 0x1F bits 0-3 show bridge pin inputs; bits 4-7 read 1.
// - 0x20 masks each supply status bit; 1 blocks, 0 passes, default 0.
// - 0x21 and 0x22 mask standby and regulator status bits by position.
// - 0x23 bits 0-5 mask the six expander interrupts; 1 blocks.
// - 0x24 bits 0-4 mask bus alerts and temperature alert; 1 blocks.
// - 0x25 bits 0-7 globally block each summary and controller interrupt.
module board_status_regs (
  input logic clk,
  input logic rst,
  input logic scl_in,
  input logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input logic [7:0] reset_event_local,
  input logic [6:0] reset_event_remote,
  input logic [7:0] supply_status_in,
  input logic standby_power_good,
  input logic core_rail_ready,
  input logic core_rail_overtemp,
  input logic analog_rail_ready,
  input logic analog_rail_overtemp,
  input logic rail_3p3_ready,
  input logic rail_3p3_overtemp,
  input logic [5:0] expander_irq_n,
  input logic trusted_module_irq_n,
  input logic [2:0] module_board_type,
  input logic module_gig_link_n,
  input logic module_suspend_stat_n,
  input logic module_sleep_s3_n,
  input logic module_sleep_s4_n,
  input logic module_sleep_s5_n,
  input logic upper_lamp_selected_n,
  input logic lower_lamp_selected_n,
  input logic front_button_level,
  input logic board_button_level,
  input logic header_button_level,
  input logic lamp_select_button,
  input logic header_uart_select,
  input logic mgmt_uart_select,
  input logic module_pcie_reset_level,
  input logic [3:0] bridge_pin_input,
  input logic power_mgmt_bus_alert,
  input logic core_rail_bus_alert,
  input logic rail_3p3_bus_alert,
  input logic analog_rail_bus_alert,
  input logic temp_alert_n,
  input logic optical_port_irq_n,
  output logic mgmt_irq_n,
  output logic mgmt_power_irq_n,
  output logic mgmt_optical_irq_n
);
  typedef enum logic [2:0] {IDLE, ADDR, ACK, WR_BYTE, RD_BYTE, RD_ACK} slv_st_t;

  typedef struct packed {
    slv_st_t st;
    logic [2:0] bitcnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic ptr_set;
    logic rw;
    logic ack_on;
    logic sda_oe;
    logic scl_d;
    logic sda_d;
    logic [7:0] ev_loc_d;
    logic [6:0] ev_rem_d;
    logic [7:0] rst_loc;
    logic [6:0] rst_rem;
    logic [7:0] m_sup;
    logic [7:0] m_stby;
    logic [7:0] m_reg;
    logic [7:0] m_exp;
    logic [7:0] m_alert;
    logic [7:0] m_glob;
    logic irq_n;
    logic pwr_irq_n;
    logic opt_irq_n;
  } state_t;

  localparam state_t RST_STATE = '{
    st: IDLE,
    scl_d: 1'b1,
    sda_d: 1'b1,
    m_sup: board_regs_pkg::MASK_RST,
    m_stby: board_regs_pkg::MASK_RST,
    m_reg: board_regs_pkg::MASK_RST,
    m_exp: board_regs_pkg::MASK_RST,
    m_alert: board_regs_pkg::MASK_RST,
    m_glob: board_regs_pkg::MASK_RST,
    irq_n: 1'b1,
    pwr_irq_n: 1'b1,
    opt_irq_n: 1'b1,
    default: '0
  };

  state_t s_r;
  state_t s_nxt;
  board_regs_pkg::pins_t raw_b;
  board_regs_pkg::pins_t pin_s;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic sup_act, stby_act, reg_act, exp_act, alert_act, tpm_act;
  logic [7:0] summary;

  pin_sync_if #(.W(board_regs_pkg::PINS_W)) pins ();

  // Gather pins for the synchroniser
  always_comb begin
    raw_b = '0;
    raw_b.scl = scl_in;
    raw_b.sda = sda_in;
    raw_b.ev_loc = reset_event_local;
    raw_b.ev_rem = reset_event_remote;
    raw_b.supply = supply_status_in;
    raw_b.stby = standby_power_good;
    raw_b.rails = {rail_3p3_overtemp, rail_3p3_ready, analog_rail_overtemp,
                   analog_rail_ready, core_rail_overtemp, core_rail_ready};
    raw_b.exp_n = expander_irq_n;
    raw_b.tpm_n = trusted_module_irq_n;
    raw_b.cpu = {module_sleep_s5_n, module_sleep_s4_n, module_sleep_s3_n,
                 module_suspend_stat_n, module_gig_link_n, module_board_type};
    raw_b.lamp_n = {lower_lamp_selected_n, upper_lamp_selected_n};
    raw_b.dbg = {module_pcie_reset_level, mgmt_uart_select, header_uart_select,
                 lamp_select_button, header_button_level, board_button_level,
                 front_button_level};
    raw_b.alert = {temp_alert_n, analog_rail_bus_alert, rail_3p3_bus_alert,
                   core_rail_bus_alert, power_mgmt_bus_alert};
    raw_b.bridge = bridge_pin_input;
    raw_b.optical_n = optical_port_irq_n;
  end

  assign pins.raw = raw_b;
  assign pin_s = board_regs_pkg::pins_t'(pins.synced);

  pin_sync #(
    .W(board_regs_pkg::PINS_W),
    .RST_VAL(board_regs_pkg::PINS_RST)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .p(pins)
  );

  // Bus line events from synchronised levels
  assign scl_rise = pin_s.scl & ~s_r.scl_d;
  assign scl_fall = ~pin_s.scl & s_r.scl_d;
  assign start_det = pin_s.scl & s_r.scl_d & s_r.sda_d & ~pin_s.sda;
  assign stop_det = pin_s.scl & s_r.scl_d & ~s_r.sda_d & pin_s.sda;

  // Sources that differ from their normal level and, except the trusted module, pass the local mask
  assign sup_act = |((pin_s.supply ^ board_regs_pkg::SUPPLY_NORMAL) & ~s_r.m_sup);
  assign stby_act = |(({7'h00, pin_s.stby} ^ board_regs_pkg::STANDBY_NORMAL)
                      & ~s_r.m_stby);
  assign reg_act = |(({2'b00, pin_s.rails} ^ board_regs_pkg::REG_NORMAL)
                     & ~s_r.m_reg);
  assign exp_act = |(({2'b00, pin_s.exp_n} ^ board_regs_pkg::EXP_NORMAL)
                     & ~s_r.m_exp);
  assign alert_act = |(({3'b000, pin_s.alert} ^ board_regs_pkg::ALERT_NORMAL)
                       & ~s_r.m_alert);
  assign tpm_act = ~pin_s.tpm_n;

  // Summary interrupts, active low
  assign summary = {3'b000, ~tpm_act, ~exp_act, ~reg_act, ~stby_act, ~sup_act};

  // Read data for an offset
  function automatic logic [7:0] read_reg(input logic [7:0] a);
    logic [7:0] d;
    d = board_regs_pkg::UNMAPPED_READ;
    case (a)
      board_regs_pkg::OFF_RST_LOCAL: d = s_r.rst_loc;
      board_regs_pkg::OFF_RST_REMOTE: d = {1'b0, s_r.rst_rem};
      board_regs_pkg::OFF_SUPPLY: d = pin_s.supply;
      board_regs_pkg::OFF_STANDBY: d = {7'h00, pin_s.stby};
      board_regs_pkg::OFF_REGULATOR: d = {2'b00, pin_s.rails};
      board_regs_pkg::OFF_EXP_IRQ: d = {board_regs_pkg::EXP_RSVD, pin_s.exp_n};
      board_regs_pkg::OFF_SUMMARY: d = summary;
      board_regs_pkg::OFF_CPU_MOD: d = pin_s.cpu;
      board_regs_pkg::OFF_LAMP: d = {4'h0, board_regs_pkg::LAMP_RSVD_HI, pin_s.lamp_n};
      board_regs_pkg::OFF_DEBUG: d = {pin_s.dbg[6], 1'b0, pin_s.dbg[5:0]};
      board_regs_pkg::OFF_BRIDGE: d = {board_regs_pkg::BRIDGE_RSVD, pin_s.bridge};
      board_regs_pkg::OFF_M_SUPPLY: d = s_r.m_sup;
      board_regs_pkg::OFF_M_STANDBY: d = s_r.m_stby;
      board_regs_pkg::OFF_M_REG: d = s_r.m_reg;
      board_regs_pkg::OFF_M_EXP: d = s_r.m_exp;
      board_regs_pkg::OFF_M_ALERT: d = s_r.m_alert;
      board_regs_pkg::OFF_M_GLOBAL: d = s_r.m_glob;
      default: d = board_regs_pkg::UNMAPPED_READ;
    endcase
    return d;
  endfunction

  // Slave sequencing, register writes, flags and interrupt outputs
  always_comb begin
    logic [7:0] byte_in;
    logic [7:0] rd_byte;
    logic rd_load;
    logic clr_loc;
    logic clr_rem;
    byte_in = {s_r.sh[6:0], pin_s.sda};
    rd_byte = read_reg(s_r.ptr); // Follows every register and pin change
    rd_load = 1'b0;
    clr_loc = 1'b0;
    clr_rem = 1'b0;
    s_nxt = s_r;
    case (s_r.st)
      IDLE: begin
        s_nxt.sda_oe = 1'b0;
      end
      ADDR: begin
        if (scl_rise) begin
          s_nxt.sh = byte_in;
          s_nxt.bitcnt = s_r.bitcnt + 3'h1;
          if (s_r.bitcnt == 3'h7) begin
            if (byte_in[7:1] == board_regs_pkg::MGMT_ADDR ||
                byte_in[7:1] == board_regs_pkg::HOST_ADDR) begin
              s_nxt.rw = byte_in[0];
              s_nxt.st = ACK;
            end else begin
              s_nxt.st = IDLE;
            end
          end
        end
      end
      ACK: begin
        // Pull the line low for one full bit
        if (scl_fall) begin
          if (!s_r.ack_on) begin
            s_nxt.ack_on = 1'b1;
            s_nxt.sda_oe = 1'b1;
          end else begin
            s_nxt.ack_on = 1'b0;
            s_nxt.sda_oe = 1'b0;
            s_nxt.bitcnt = 3'h0;
            if (s_r.rw) begin
              rd_load = 1'b1;
            end else begin
              s_nxt.st = WR_BYTE;
            end
          end
        end
      end
      WR_BYTE: begin
        if (scl_rise) begin
          s_nxt.sh = byte_in;
          s_nxt.bitcnt = s_r.bitcnt + 3'h1;
          if (s_r.bitcnt == 3'h7) begin
            s_nxt.st = ACK;
            if (!s_r.ptr_set) begin
              s_nxt.ptr = byte_in;
              s_nxt.ptr_set = 1'b1;
            end else begin
              s_nxt.ptr = s_r.ptr + 8'h01;
              // Only mask registers take data
              case (s_r.ptr)
                board_regs_pkg::OFF_M_SUPPLY: s_nxt.m_sup = byte_in;
                board_regs_pkg::OFF_M_STANDBY: s_nxt.m_stby = byte_in;
                board_regs_pkg::OFF_M_REG: s_nxt.m_reg = byte_in;
                board_regs_pkg::OFF_M_EXP: s_nxt.m_exp = byte_in;
                board_regs_pkg::OFF_M_ALERT: s_nxt.m_alert = byte_in;
                board_regs_pkg::OFF_M_GLOBAL: s_nxt.m_glob = byte_in;
                default: s_nxt.m_sup = s_r.m_sup;
              endcase
            end
          end
        end
      end
      RD_BYTE: begin
        if (scl_fall) begin
          if (s_r.bitcnt == 3'h7) begin
            s_nxt.sda_oe = 1'b0;
            s_nxt.st = RD_ACK;
          end else begin
            s_nxt.sh = {s_r.sh[6:0], 1'b0};
            s_nxt.sda_oe = ~s_r.sh[6];
            s_nxt.bitcnt = s_r.bitcnt + 3'h1;
          end
        end
      end
      RD_ACK: begin
        // Master ack continues the burst, nack ends it
        if (scl_rise) begin
          s_nxt.ack_on = ~pin_s.sda;
        end
        if (scl_fall) begin
          s_nxt.ack_on = 1'b0;
          if (s_r.ack_on) begin
            rd_load = 1'b1;
          end else begin
            s_nxt.st = IDLE;
          end
        end
      end
      default: begin
        s_nxt.st = IDLE;
      end
    endcase
    // Load a byte to send, first bit driven now
    if (rd_load) begin
      s_nxt.sh = rd_byte;
      s_nxt.sda_oe = ~rd_byte[7];
      s_nxt.ptr = s_r.ptr + 8'h01;
      s_nxt.bitcnt = 3'h0;
      s_nxt.st = RD_BYTE;
      clr_loc = (s_r.ptr == board_regs_pkg::OFF_RST_LOCAL);
      clr_rem = (s_r.ptr == board_regs_pkg::OFF_RST_REMOTE);
    end
    if (start_det) begin
      s_nxt.st = ADDR;
      s_nxt.bitcnt = 3'h0;
      s_nxt.ptr_set = 1'b0;
      s_nxt.ack_on = 1'b0;
      s_nxt.sda_oe = 1'b0;
    end
    if (stop_det) begin
      s_nxt.st = IDLE;
      s_nxt.ack_on = 1'b0;
      s_nxt.sda_oe = 1'b0;
    end
    // Sticky reset flags, clear on read, a new event wins
    s_nxt.rst_loc = ((s_r.rst_loc & ~{8{clr_loc}})
                     | (pin_s.ev_loc & ~s_r.ev_loc_d))
                    & board_regs_pkg::RST_LOCAL_BITS;
    s_nxt.rst_rem = ((s_r.rst_rem & ~{7{clr_rem}})
                     | (pin_s.ev_rem & ~s_r.ev_rem_d))
                    & board_regs_pkg::RST_REMOTE_BITS;
    s_nxt.ev_loc_d = pin_s.ev_loc;
    s_nxt.ev_rem_d = pin_s.ev_rem;
    s_nxt.scl_d = pin_s.scl;
    s_nxt.sda_d = pin_s.sda;
    // Global gating onto the controller outputs
    s_nxt.irq_n = ~|({tpm_act, alert_act, exp_act, reg_act, stby_act, sup_act}
                     & ~s_r.m_glob[5:0]);
    s_nxt.pwr_irq_n = ~((stby_act | reg_act) & ~s_r.m_glob[6]);
    s_nxt.opt_irq_n = ~(~pin_s.optical_n & ~s_r.m_glob[7]);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= RST_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = s_r.sda_oe;
  assign mgmt_irq_n = s_r.irq_n;
  assign mgmt_power_irq_n = s_r.pwr_irq_n;
  assign mgmt_optical_irq_n = s_r.opt_irq_n;
endmodule // board_status_regs

// ===== tb/board_regs_props.sv
`timescale 1ns/1ns
module board_regs_props (
  input logic clk,
  input logic rst,
  input logic scl_in,
  input logic sda_out,
  input logic sda_oe,
  input logic [7:0] supply_status_in,
  input logic standby_power_good,
  input logic core_rail_ready,
  input logic core_rail_overtemp,
  input logic analog_rail_ready,
  input logic analog_rail_overtemp,
  input logic rail_3p3_ready,
  input logic rail_3p3_overtemp,
  input logic [5:0] expander_irq_n,
  input logic trusted_module_irq_n,
  input logic power_mgmt_bus_alert,
  input logic core_rail_bus_alert,
  input logic rail_3p3_bus_alert,
  input logic analog_rail_bus_alert,
  input logic temp_alert_n,
  input logic optical_port_irq_n,
  input logic mgmt_irq_n,
  input logic mgmt_power_irq_n,
  input logic mgmt_optical_irq_n
);
  logic [2:0] age_r;
  logic settled;
  logic pwr_src;
  logic any_src;
  // Age after reset, so refilling input stages are not judged
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      age_r <= 3'h0;
    end else if (age_r != 3'h7) begin
      age_r <= age_r + 3'h1;
    end
  end
  // Sources away from their quiet levels
  assign settled = age_r == 3'h7;
  assign pwr_src = !standby_power_good || !core_rail_ready || core_rail_overtemp ||
    !analog_rail_ready || analog_rail_overtemp || !rail_3p3_ready || rail_3p3_overtemp;
  assign any_src = pwr_src || supply_status_in != 8'hEE || expander_irq_n != 6'h3F ||
    !trusted_module_irq_n || !(power_mgmt_bus_alert && core_rail_bus_alert &&
    rail_3p3_bus_alert && analog_rail_bus_alert && temp_alert_n);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_all_quiet;
    (settled && !any_src) [*5];
  endsequence
  sequence s_pwr_quiet;
    (settled && !pwr_src) [*5];
  endsequence
  property p_after_reset;
    $fell(rst) |-> mgmt_irq_n && mgmt_power_irq_n && mgmt_optical_irq_n && !sda_oe;
  endproperty
  property p_irq_cause;
    settled && !mgmt_irq_n |-> $past(any_src, 3);
  endproperty
  property p_irq_quiet;
    s_all_quiet |-> mgmt_irq_n;
  endproperty
  property p_pwr_cause;
    settled && !mgmt_power_irq_n |-> $past(pwr_src, 3);
  endproperty
  property p_pwr_quiet;
    s_pwr_quiet |-> mgmt_power_irq_n;
  endproperty
  property p_opt_cause;
    settled && !mgmt_optical_irq_n |-> !$past(optical_port_irq_n, 3);
  endproperty
  property p_opt_idle;
    settled && $past(optical_port_irq_n, 3) |-> mgmt_optical_irq_n;
  endproperty
  property p_sda_edge;
    $changed(sda_oe) |-> !scl_in && !$past(scl_in, 2);
  endproperty
  property p_sda_low;
    sda_oe |-> !sda_out;
  endproperty
  a_after_reset: assert property (p_after_reset)
    else $error("outputs not idle after reset");
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt without an active source");
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt held while all sources quiet");
  a_pwr_cause: assert property (p_pwr_cause)
    else $error("power interrupt without a rail source");
  a_pwr_quiet: assert property (p_pwr_quiet)
    else $error("power interrupt held while rails quiet");
  a_opt_cause: assert property (p_opt_cause)
    else $error("optical interrupt without its input");
  a_opt_idle: assert property (p_opt_idle)
    else $error("optical interrupt while input idle");
  a_sda_edge: assert property (p_sda_edge)
    else $error("data line moved while clock high");
  a_sda_low: assert property (p_sda_low)
    else $error("data line driven high");
endmodule // board_regs_props

bind board_status_regs board_regs_props u_board_regs_props (
  .clk, .rst, .scl_in, .sda_out, .sda_oe, .supply_status_in, .standby_power_good,
  .core_rail_ready, .core_rail_overtemp, .analog_rail_ready, .analog_rail_overtemp,
  .rail_3p3_ready, .rail_3p3_overtemp, .expander_irq_n, .trusted_module_irq_n,
  .power_mgmt_bus_alert, .core_rail_bus_alert, .rail_3p3_bus_alert, .analog_rail_bus_alert,
  .temp_alert_n, .optical_port_irq_n, .mgmt_irq_n, .mgmt_power_irq_n, .mgmt_optical_irq_n
);

// ===== tb/i2c_master_model.sv
`timescale 1ns/1ns
module i2c_master_model (
  input logic clk,
  input logic sda_bus,
  output logic scl,
  output logic sda_drv
);
  // Bus idles released
  initial begin
    scl = 1'h1;
    sda_drv = 1'h1;
  end
  // Quarter bit time, moved just after the edge
  task automatic q();
    repeat (3) @(posedge clk);
    #1;
  endtask
  // One bit, sampled while the clock is high
  task automatic bt(input logic b, output logic r);
    sda_drv = b;
    q();
    scl = 1'h1;
    q();
    r = sda_bus;
    q();
    scl = 1'h0;
    q();
  endtask
  task automatic start();
    sda_drv = 1'h1;
    q();
    scl = 1'h1;
    q();
    sda_drv = 1'h0;
    q();
    scl = 1'h0;
    q();
  endtask
  task automatic stop();
    sda_drv = 1'h0;
    q();
    scl = 1'h1;
    q();
    sda_drv = 1'h1;
    q();
  endtask
  // Byte out, MSB first, then the slave's acknowledge
  task automatic tx(input logic [7:0] b, inout logic ok);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      bt(b[i], x);
    end
    bt(1'h1, x);
    ok = ok & !x;
  endtask
  task automatic rx(input logic last, output logic [7:0] d);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      bt(1'h1, d[i]);
    end
    bt(last, x);
  endtask
  // Pointer then one data byte
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
      output logic ok);
    ok = 1'h1;
    start();
    tx({a, 1'h0}, ok);
    tx(p, ok);
    tx(d, ok);
    stop();
  endtask
  // Pointer, repeated start, one byte back
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d,
      output logic ok);
    ok = 1'h1;
    start();
    tx({a, 1'h0}, ok);
    tx(p, ok);
    start();
    tx({a, 1'h1}, ok);
    rx(1'h1, d);
    stop();
  endtask
  // Two bytes in one burst, the first acknowledged
  task automatic rd2(input logic [6:0] a, input logic [7:0] p, output logic [15:0] d,
      output logic ok);
    ok = 1'h1;
    start();
    tx({a, 1'h0}, ok);
    tx(p, ok);
    start();
    tx({a, 1'h1}, ok);
    rx(1'h0, d[15:8]);
    rx(1'h1, d[7:0]);
    stop();
  endtask
endmodule // i2c_master_model

// ===== tb/tb.sv
`timescale 1ns/1ns
module tb;
  localparam logic [48:0] QUIET = {1'h1, 1'h1, 5'h1F, 4'h0, 7'h00, 2'h3, 8'h00, 6'h3F,
    6'h15, 1'h1, 8'hEE};
  localparam logic [48:0] PAT = 49'h1A5C396E15A3C;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic scl, sda_drv, sda_out, sda_oe, sda_bus, irq_n, pwr_n, opt_n;
  logic [48:0] pv = QUIET;
  logic [7:0] ev_l = 8'h00;
  logic [6:0] ev_r = 7'h00;
  logic [6:0] adr = board_regs_pkg::MGMT_ADDR;
  int n_mismatch = 0;
  int compares = 0;
  // Open-drain data line with pull-up
  assign sda_bus = sda_drv & (sda_oe ? sda_out : 1'h1);
  board_status_regs u_board_status_regs (
    .clk, .rst, .scl_in(scl), .sda_in(sda_bus), .sda_out, .sda_oe,
    .reset_event_local(ev_l), .reset_event_remote(ev_r), .supply_status_in(pv[7:0]),
    .standby_power_good(pv[8]), .core_rail_ready(pv[9]), .core_rail_overtemp(pv[10]),
    .analog_rail_ready(pv[11]), .analog_rail_overtemp(pv[12]), .rail_3p3_ready(pv[13]),
    .rail_3p3_overtemp(pv[14]), .expander_irq_n(pv[20:15]), .trusted_module_irq_n(pv[47]),
    .module_board_type(pv[23:21]), .module_gig_link_n(pv[24]), .module_suspend_stat_n(pv[25]),
    .module_sleep_s3_n(pv[26]), .module_sleep_s4_n(pv[27]), .module_sleep_s5_n(pv[28]),
    .upper_lamp_selected_n(pv[29]), .lower_lamp_selected_n(pv[30]),
    .front_button_level(pv[31]), .board_button_level(pv[32]), .header_button_level(pv[33]),
    .lamp_select_button(pv[34]), .header_uart_select(pv[35]), .mgmt_uart_select(pv[36]),
    .module_pcie_reset_level(pv[37]), .bridge_pin_input(pv[41:38]),
    .power_mgmt_bus_alert(pv[42]), .core_rail_bus_alert(pv[43]), .rail_3p3_bus_alert(pv[44]),
    .analog_rail_bus_alert(pv[45]), .temp_alert_n(pv[46]), .optical_port_irq_n(pv[48]),
    .mgmt_irq_n(irq_n), .mgmt_power_irq_n(pwr_n), .mgmt_optical_irq_n(opt_n)
  );
  i2c_master_model u_i2c_master_model (.clk, .sda_bus, .scl, .sda_drv);
  // 10 MHz clock
  always #50 clk = ~clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Comparisons of bytes and of single flags
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask
  // Register access, acknowledge checked
  task automatic rd(input logic [7:0] p, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_i2c_master_model.rd(adr, p, d, ok);
    chk1(ok, 1'h1);
    chk8(d, exp);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic ok;
    u_i2c_master_model.wr(adr, p, d, ok);
    chk1(ok, 1'h1);
  endtask
  // Event edges latch flags; a read clears them
  task automatic t_flags();
    rd(8'h0E, 8'h00);
    ev_l = 8'hFF;
    ev_r = 7'h7F;
    cyc(4);
    ev_l = 8'h00;
    ev_r = 7'h00;
    cyc(4);
    rd(8'h0E, 8'hF7);
    rd(8'h0E, 8'h00);
    rd(8'h0F, 8'h7F);
    rd(8'h0F, 8'h00);
  endtask
  // Mask defaults and full width, both addresses, refused address, unmapped read
  task automatic t_masks();
    logic ok;
    logic [15:0] d2;
    for (int i = 0; i < 6; i++) begin
      rd(8'h20 + i[7:0], 8'h00);
      wr(8'h20 + i[7:0], 8'hA5 ^ i[7:0]);
    end
    u_i2c_master_model.rd2(adr, 8'h24, d2, ok);
    chk1(ok, 1'h1);
    chk8(d2[15:8], 8'hA1);
    chk8(d2[7:0], 8'hA0);
    adr = board_regs_pkg::HOST_ADDR;
    for (int i = 0; i < 6; i++) begin
      rd(8'h20 + i[7:0], 8'hA5 ^ i[7:0]);
      wr(8'h20 + i[7:0], 8'h00);
    end
    adr = board_regs_pkg::MGMT_ADDR;
    u_i2c_master_model.wr(7'h33, 8'h20, 8'hFF, ok);
    chk1(ok, 1'h0);
    rd(8'h20, 8'h00);
    rd(8'h15, board_regs_pkg::UNMAPPED_READ);
  endtask
  // Status images against their inputs, read-only write dropped
  task automatic t_status(input logic [48:0] v);
    pv = v;
    cyc(4);
    rd(8'h10, v[7:0]);
    rd(8'h11, {7'h00, v[8]});
    rd(8'h12, {2'h0, v[14:9]});
    rd(8'h13, {2'h3, v[20:15]});
    rd(8'h18, v[28:21]);
    rd(8'h1B, {4'h0, 2'h3, v[30:29]});
    rd(8'h1C, {v[37], 1'h0, v[36:31]});
    rd(8'h1F, {4'hF, v[41:38]});
    wr(8'h10, ~v[7:0]);
    rd(8'h10, v[7:0]);
    pv = QUIET;
  endtask
  // One source per group through summary, output, own mask (none for the trusted module) and global mask
  task automatic t_irq();
    int bit_of[6] = '{0, 8, 9, 15, 42, 47};
    logic [7:0] sum_of[6] = '{8'h1E, 8'h1D, 8'h1B, 8'h17, 8'h1F, 8'h0F};
    for (int g = 0; g < 6; g++) begin
      pv[bit_of[g]] = ~pv[bit_of[g]];
      cyc(6);
      chk1(irq_n, 1'h0);
      chk1(pwr_n, !(g == 1 || g == 2));
      rd(8'h14, sum_of[g]);
      if (g < 5) begin
        wr(8'h20 + g[7:0], 8'h01);
        cyc(2);
        chk1(irq_n, 1'h1);
        wr(8'h20 + g[7:0], 8'h00);
      end
      wr(8'h25, 8'h01 << g);
      cyc(2);
      chk1(irq_n, 1'h1);
      wr(8'h25, 8'h00);
      pv = QUIET;
    end
    pv[48] = 1'h0;
    cyc(6);
    chk1(opt_n, 1'h0);
    wr(8'h25, 8'h80);
    chk1(opt_n, 1'h1);
    wr(8'h25, 8'h00);
    pv[48] = 1'h1;
  endtask
  // Counts and verdict
  task automatic results();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    cyc(12);
    rst = 1'h0;
    cyc(6);
    t_flags();
    t_masks();
    t_status(PAT);
    t_status(~PAT);
    t_irq();
    results();
  end
  // Watchdog, well beyond the expected run
  initial begin
    cyc(50000);
    n_mismatch++;
    results();
  end
endmodule // tb
